// ---- hw/sfcfe_top.sv ----
// Purpose: Command front end of a serial NOR flash, seen from the pins
// Assumes: Host owns select and serial clock; clk is far faster than sclk
// Notes:   Modes 0 and 3 both served by edge detection on sampled sclk
`timescale 1ns/10ps
`default_nettype none
`include "sfcfe_defines.svh"

// Summary of operation
// R01: Host checks device status before issuing any command.
// R02: Unknown command code sends device to standby until next select fall.
// R03: In standby the serial output stays undriven.
// R04: Valid command keeps device active until the next select rise.
// R05: Input sampled on sclk rise, output launched on sclk fall.
// R06: Clock modes 0 and 3 both work, idle level does not matter.
// R07: Host chooses the mode by its clock idle level.
// R08: Read commands send data; select may rise after any output bit.
// R09: Write commands must end on a byte boundary or are rejected.
// R10: Array access ignored while status write, program or erase runs.
// R11: Quad command mode moves codes, addresses and data on four lines.
// R12: Code 35H enters quad command mode.
// R13: Code F5H returns to single-line operation.
// R14: Code EBH selects fast quad read mode.
// R15: Fast quad read uses six dummy clocks instead of four.
// R16: Addresses decode into 4KB sectors, 32KB and 64KB blocks.
module sfcfe_top
  import sfcfe_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rstn,
  // Serial pins
  input  wire logic                csN,
  input  wire logic                sclk,
  input  wire logic [3:0]          ioIn,
  output logic      [3:0]          ioOut,
  output logic      [3:0]          ioOeN,
  // Core status
  input  wire logic                busy,
  // Decoded commands
  output logic                     cmdValid,
  output sfcfe_pkg::sfcfe_cmd_t    cmd,
  // Read data from the core
  input  wire logic [7:0]          rdData,
  input  wire logic                rdValid,
  output logic                     rdReady,
  // Mode status
  output logic                     active,
  output logic                     quad_command_mode,
  output logic                     fast_quad_read_mode
);

  import sfcfe_pkg::*;

  // ***************************************************************
  // Pin sampling and edge detection
  // ***************************************************************
  logic       csNSync;
  logic       sclkSync;
  logic [3:0] ioSync;
  logic       csPrev_reg;
  logic       sclkPrev_reg;
  logic       sclkRise;
  logic       sclkFall;
  logic       csFall;
  logic       csRise;

  sfcfe_sync #(.W(6), .INIT(6'h30)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .din  ({csN, sclk, ioIn}),
    .dout ({csNSync, sclkSync, ioSync})
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      csPrev_reg   <= 1'b1;
      sclkPrev_reg <= 1'b1;
    end else begin
      csPrev_reg   <= csNSync;
      sclkPrev_reg <= sclkSync;
    end
  end

  // Either idle level works: only edges inside a frame count
  assign sclkRise = sclkSync && !sclkPrev_reg && !csNSync; // [R05] [R06]
  assign sclkFall = !sclkSync && sclkPrev_reg && !csNSync; // [R05] [R06]
  assign csFall   = csPrev_reg && !csNSync;
  assign csRise   = !csPrev_reg && csNSync;

  // ***************************************************************
  // Command classification
  // ***************************************************************
  function automatic sfcfe_class_t classify(input logic [7:0] op);
    sfcfe_class_t c;
    c = '0;
    case (op)
      `SFCFE_OP_READ, `SFCFE_OP_FAST_READ, `SFCFE_OP_SFDP,
      `SFCFE_OP_QUAD_READ: c = '{1'b1, 1'b1, 1'b1, 1'b1};
      `SFCFE_OP_STATUS, `SFCFE_OP_IDENT: c = '{1'b1, 1'b1, 1'b0, 1'b0};
      `SFCFE_OP_SECT_ER, `SFCFE_OP_BLK32_ER, `SFCFE_OP_BLK64_ER,
      `SFCFE_OP_PAGE_PGM: c = '{1'b1, 1'b0, 1'b1, 1'b1};
      `SFCFE_OP_CHIP_ER_A, `SFCFE_OP_CHIP_ER_B,
      `SFCFE_OP_STAT_WR: c = '{1'b1, 1'b0, 1'b0, 1'b1};
      `SFCFE_OP_WREN, `SFCFE_OP_WRDI, `SFCFE_OP_PWR_DOWN, `SFCFE_OP_PWR_UP,
      `SFCFE_OP_SUSPEND, `SFCFE_OP_RESUME, `SFCFE_OP_QUAD_ON,
      `SFCFE_OP_QUAD_OFF: c = '{1'b1, 1'b0, 1'b0, 1'b0};
      default: c = '0;
    endcase
    return c;
  endfunction : classify

  // ***************************************************************
  // Frame state
  // ***************************************************************
  sfcfe_state_t state_reg;
  sfcfe_class_t cls_reg;
  sfcfe_class_t opCls;
  logic [7:0]   sr_reg;
  logic [7:0]   srNext;
  logic [7:0]   opcode_reg;
  logic [23:0]  addr_reg;
  logic [23:0]  addrNext;
  logic [4:0]   addrCnt_reg;
  logic [4:0]   addrCntNext;
  logic [2:0]   bitCnt_reg;
  logic [2:0]   bitNext;
  logic [3:0]   dummy_reg;
  logic [3:0]   dummyLoad;
  logic         wide_reg;
  logic         laneQuad;
  logic         issueRead;
  logic         commitWrite;

  // Opcode lanes follow quad mode, later phases also widen for EBH
  assign laneQuad    = (state_reg == SFCFE_CMD) ? quad_command_mode : wide_reg; // [R11]
  assign srNext      = laneQuad ? {sr_reg[3:0], ioSync} : {sr_reg[6:0], ioSync[0]};
  assign addrNext    = laneQuad ? {addr_reg[19:0], ioSync} : {addr_reg[22:0], ioSync[0]};
  assign bitNext     = bitCnt_reg + (laneQuad ? `SFCFE_STEP_FOUR : `SFCFE_STEP_ONE);
  assign addrCntNext = addrCnt_reg + (laneQuad ? `SFCFE_LANE_FOUR : `SFCFE_LANE_ONE);
  assign opCls       = classify(srNext);

  always_comb begin
    dummyLoad = `SFCFE_DUMMY_NONE;
    if (opcode_reg == `SFCFE_OP_QUAD_READ) begin
      dummyLoad = fast_quad_read_mode ? `SFCFE_DUMMY_FAST : `SFCFE_DUMMY_QUAD; // [R15]
    end else if (opcode_reg != `SFCFE_OP_READ) begin
      dummyLoad = quad_command_mode ? `SFCFE_DUMMY_QUAD : `SFCFE_DUMMY_SINGLE;
    end
  end

  // Read issued once its address and dummy phase are through
  assign issueRead = sclkRise && (
    (state_reg == SFCFE_CMD && bitNext == 3'h0 && opCls.known && opCls.isRead
      && !opCls.hasAddr) ||
    (state_reg == SFCFE_ADDR && addrCntNext == `SFCFE_ADDR_BITS && cls_reg.isRead
      && !busy && dummyLoad == `SFCFE_DUMMY_NONE) ||
    (state_reg == SFCFE_DUMMY && dummy_reg == 4'h1 && !busy)); // [R10]

  // Write-type commands execute only on a whole-byte select rise
  assign commitWrite = csRise && state_reg == SFCFE_WIN && bitCnt_reg == 3'h0
    && !(cls_reg.isArray && busy); // [R09] [R10]

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= SFCFE_IDLE;
      cls_reg     <= '0;
      sr_reg      <= 8'h00;
      opcode_reg  <= 8'h00;
      addr_reg    <= 24'h000000;
      addrCnt_reg <= 5'h00;
      bitCnt_reg  <= 3'h0;
      dummy_reg   <= 4'h0;
      wide_reg    <= 1'b0;
    end else if (csRise) begin
      state_reg <= SFCFE_IDLE; // [R04]
    end else if (csFall) begin
      state_reg   <= SFCFE_CMD; // [R02]
      bitCnt_reg  <= 3'h0;
      addrCnt_reg <= 5'h00;
    end else if (sclkRise) begin
      case (state_reg)
        SFCFE_CMD: begin
          sr_reg     <= srNext;
          bitCnt_reg <= bitNext;
          if (bitNext == 3'h0) begin
            opcode_reg <= srNext;
            cls_reg    <= opCls;
            wide_reg   <= quad_command_mode || srNext == `SFCFE_OP_QUAD_READ;
            if (!opCls.known) begin
              state_reg <= SFCFE_STBY; // [R02]
            end else if (opCls.hasAddr) begin
              state_reg <= SFCFE_ADDR; // [R04]
            end else if (opCls.isRead) begin
              state_reg <= SFCFE_DOUT; // [R08]
            end else begin
              state_reg <= SFCFE_WIN;
            end
          end
        end
        SFCFE_ADDR: begin
          addr_reg    <= addrNext;
          addrCnt_reg <= addrCntNext;
          bitCnt_reg  <= bitNext;
          if (addrCntNext == `SFCFE_ADDR_BITS) begin
            if (!cls_reg.isRead) begin
              state_reg <= SFCFE_WIN;
            end else if (busy) begin
              state_reg <= SFCFE_STBY; // [R10]
            end else if (dummyLoad == `SFCFE_DUMMY_NONE) begin
              state_reg <= SFCFE_DOUT;
            end else begin
              dummy_reg <= dummyLoad; // [R15]
              state_reg <= SFCFE_DUMMY;
            end
          end
        end
        SFCFE_DUMMY: begin
          dummy_reg <= dummy_reg - 4'h1;
          if (dummy_reg == 4'h1) begin
            state_reg <= SFCFE_DOUT;
          end
        end
        SFCFE_WIN: begin
          sr_reg     <= srNext;
          bitCnt_reg <= bitNext;
        end
        default: state_reg <= state_reg;
      endcase
    end
  end

  // ***************************************************************
  // Decoded command output
  // ***************************************************************
  logic [23:0] addrFull;

  // Last address bit is still in flight when a read issues from ADDR
  assign addrFull = (state_reg == SFCFE_ADDR) ? addrNext : addr_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmdValid <= 1'b0;
      cmd      <= '0;
    end else begin
      cmdValid <= issueRead || commitWrite;
      if (issueRead || commitWrite) begin
        cmd.opcode <= (state_reg == SFCFE_CMD) ? srNext : opcode_reg;
        cmd.addr   <= addrFull;
        cmd.sector <= addrFull[23:`SFCFE_SECT_LSB]; // [R16]
        cmd.blk32  <= addrFull[23:`SFCFE_BLK32_LSB]; // [R16]
        cmd.blk64  <= addrFull[23:`SFCFE_BLK64_LSB]; // [R16]
      end
    end
  end

  // ***************************************************************
  // Mode flags
  // ***************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      quad_command_mode   <= 1'b0;
      fast_quad_read_mode <= 1'b0;
      active              <= 1'b0;
    end else begin
      if (commitWrite && opcode_reg == `SFCFE_OP_QUAD_ON) begin
        quad_command_mode <= 1'b1; // [R12]
      end else if (commitWrite && opcode_reg == `SFCFE_OP_QUAD_OFF) begin
        quad_command_mode <= 1'b0; // [R13]
      end
      if (sclkRise && state_reg == SFCFE_CMD && bitNext == 3'h0
          && srNext == `SFCFE_OP_QUAD_READ) begin
        fast_quad_read_mode <= 1'b1; // [R14]
      end
      active <= !csRise && (state_reg != SFCFE_IDLE) && (state_reg != SFCFE_STBY)
        && (state_reg != SFCFE_CMD); // [R04]
    end
  end

  // ***************************************************************
  // Data out path
  // ***************************************************************
  logic [7:0] bufData;
  logic       bufValid;
  logic       bufPop;
  logic [7:0] outByte;
  logic [7:0] outSr_reg;
  logic [2:0] outLeft_reg;

  assign bufPop  = sclkFall && state_reg == SFCFE_DOUT && outLeft_reg == 3'h0;
  assign outByte = bufValid ? bufData : `SFCFE_IDLE_BYTE;

  sfcfe_buf u_buf (
    .clk      (clk),
    .rstn     (rstn),
    .flush    (csRise),
    .inData   (rdData),
    .inValid  (rdValid),
    .inReady  (rdReady),
    .outData  (bufData),
    .outValid (bufValid),
    .outReady (bufPop)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ioOut       <= 4'h0;
      ioOeN       <= `SFCFE_OE_OFF;
      outSr_reg   <= 8'h00;
      outLeft_reg <= 3'h0;
    end else if (csRise || state_reg != SFCFE_DOUT) begin
      ioOeN       <= `SFCFE_OE_OFF; // [R03]
      outLeft_reg <= 3'h0;
    end else if (sclkFall) begin
      // Launch on the falling edge only
      if (outLeft_reg == 3'h0) begin
        if (wide_reg) begin
          ioOut       <= outByte[7:4]; // [R05] [R11]
          outSr_reg   <= {outByte[3:0], 4'h0};
          outLeft_reg <= `SFCFE_OUT_QD_LEFT;
          ioOeN       <= `SFCFE_OE_QUAD;
        end else begin
          ioOut[`SFCFE_SO_LANE] <= outByte[7]; // [R05]
          outSr_reg   <= {outByte[6:0], 1'b0};
          outLeft_reg <= `SFCFE_OUT_ONE_LEFT;
          ioOeN       <= `SFCFE_OE_SINGLE;
        end
      end else if (wide_reg) begin
        ioOut       <= outSr_reg[7:4];
        outSr_reg   <= {outSr_reg[3:0], 4'h0};
        outLeft_reg <= outLeft_reg - `SFCFE_STEP_FOUR;
      end else begin
        ioOut[`SFCFE_SO_LANE] <= outSr_reg[7];
        outSr_reg   <= {outSr_reg[6:0], 1'b0};
        outLeft_reg <= outLeft_reg - `SFCFE_STEP_ONE;
      end
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  sfcfe_class_t cmdCls;

  assign cmdCls = classify(cmd.opcode);
  standby_hiz_a : assert property (@(posedge clk) disable iff (!rstn) // [R03]
    (state_reg == SFCFE_STBY) |=> (ioOeN == `SFCFE_OE_OFF))
    else $error("output driven in standby");

  unknown_stby_a : assert property (@(posedge clk) disable iff (!rstn) // [R02]
    (sclkRise && state_reg == SFCFE_CMD && bitNext == 3'h0 && !opCls.known)
    |=> (state_reg == SFCFE_STBY))
    else $error("unknown code did not reach standby");

  stby_hold_a : assert property (@(posedge clk) disable iff (!rstn) // [R02]
    (state_reg == SFCFE_STBY && !csFall && !csRise) |=> (state_reg == SFCFE_STBY))
    else $error("standby left without select edge");

  cs_rise_end_a : assert property (@(posedge clk) disable iff (!rstn) // [R04]
    csRise |=> (state_reg == SFCFE_IDLE) ##1 !active)
    else $error("frame not closed on select rise");

  quad_enter_a : assert property (@(posedge clk) disable iff (!rstn) // [R12]
    (commitWrite && opcode_reg == `SFCFE_OP_QUAD_ON) |=> quad_command_mode)
    else $error("quad mode not entered");

  quad_exit_a : assert property (@(posedge clk) disable iff (!rstn) // [R13]
    (commitWrite && opcode_reg == `SFCFE_OP_QUAD_OFF) |=> !quad_command_mode)
    else $error("quad mode not left");

  odd_reject_a : assert property (@(posedge clk) disable iff (!rstn) // [R09]
    (csRise && bitCnt_reg != 3'h0) |=> !cmdValid)
    else $error("partial-byte write executed");

  busy_block_a : assert property (@(posedge clk) disable iff (!rstn) // [R10]
    ($past(busy) && cmdValid) |-> !cmdCls.isArray)
    else $error("array access accepted while busy");

  fall_launch_a : assert property (@(posedge clk) disable iff (!rstn) // [R05]
    $changed(ioOut) |-> $past(sclkFall))
    else $error("output changed off a falling edge");

  dummy_len_a : assert property (@(posedge clk) disable iff (!rstn) // [R15]
    ($rose(state_reg == SFCFE_DUMMY) && opcode_reg == `SFCFE_OP_QUAD_READ)
    |-> (dummy_reg == (fast_quad_read_mode ? `SFCFE_DUMMY_FAST : `SFCFE_DUMMY_QUAD)))
    else $error("wrong dummy length");

endmodule : sfcfe_top
`default_nettype wire

// ---- hw/sfcfe_defines.svh ----
// Purpose: Constants of the serial flash command front end
// Assumes: Included by the package and the top module
// Notes:   Definitions only
`ifndef SFCFE_DEFINES_SVH
`define SFCFE_DEFINES_SVH

// ***************************************************************
// Command codes
// ***************************************************************
`define SFCFE_OP_READ      8'h03
`define SFCFE_OP_FAST_READ 8'h0B
`define SFCFE_OP_SFDP      8'h5A
`define SFCFE_OP_QUAD_READ 8'hEB
`define SFCFE_OP_STATUS    8'h05
`define SFCFE_OP_IDENT     8'h9F
`define SFCFE_OP_WREN      8'h06
`define SFCFE_OP_WRDI      8'h04
`define SFCFE_OP_STAT_WR   8'h01
`define SFCFE_OP_SECT_ER   8'h20
`define SFCFE_OP_BLK32_ER  8'h52
`define SFCFE_OP_BLK64_ER  8'hD8
`define SFCFE_OP_CHIP_ER_A 8'h60
`define SFCFE_OP_CHIP_ER_B 8'hC7
`define SFCFE_OP_PAGE_PGM  8'h02
`define SFCFE_OP_PWR_DOWN  8'hB9
`define SFCFE_OP_PWR_UP    8'hAB
`define SFCFE_OP_SUSPEND   8'hB0
`define SFCFE_OP_RESUME    8'h30
`define SFCFE_OP_QUAD_ON   8'h35
`define SFCFE_OP_QUAD_OFF  8'hF5

// ***************************************************************
// Widths, counts and fields
// ***************************************************************
`define SFCFE_ADDR_BITS    5'h18
`define SFCFE_LANE_ONE     5'h01
`define SFCFE_LANE_FOUR    5'h04
`define SFCFE_STEP_ONE     3'h1
`define SFCFE_STEP_FOUR    3'h4
`define SFCFE_DUMMY_NONE   4'h0
`define SFCFE_DUMMY_QUAD   4'h4
`define SFCFE_DUMMY_FAST   4'h6
`define SFCFE_DUMMY_SINGLE 4'h8
`define SFCFE_OUT_ONE_LEFT 3'h7
`define SFCFE_OUT_QD_LEFT  3'h4
`define SFCFE_SO_LANE      1
`define SFCFE_OE_OFF       4'hF
`define SFCFE_OE_SINGLE    4'hD
`define SFCFE_OE_QUAD      4'h0
`define SFCFE_IDLE_BYTE    8'hFF
`define SFCFE_SECT_LSB     12
`define SFCFE_BLK32_LSB    15
`define SFCFE_BLK64_LSB    16

`endif

// ---- hw/sfcfe_pkg.sv ----
// Purpose: Types of the serial flash command front end
// Assumes: Constants come from sfcfe_defines.svh
// Notes:   No logic here
`include "sfcfe_defines.svh"

package sfcfe_pkg;

  // Gray codes along the usual path
  typedef enum logic [2:0] {
    SFCFE_IDLE  = 3'h0,
    SFCFE_CMD   = 3'h1,
    SFCFE_ADDR  = 3'h3,
    SFCFE_DUMMY = 3'h2,
    SFCFE_DOUT  = 3'h6,
    SFCFE_WIN   = 3'h7,
    SFCFE_STBY  = 3'h5
  } sfcfe_state_t;

  typedef struct packed {
    logic known;
    logic isRead;
    logic hasAddr;
    logic isArray;
  } sfcfe_class_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [11:0] sector;
    logic [8:0]  blk32;
    logic [7:0]  blk64;
  } sfcfe_cmd_t;

endpackage : sfcfe_pkg

// ---- hw/sfcfe_sync.sv ----
// Purpose: Two-flop synchroniser for pins entering the clk domain
// Assumes: Inputs are asynchronous levels
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none

module sfcfe_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= INIT;
      dout     <= INIT;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule : sfcfe_sync
`default_nettype wire

// ---- hw/sfcfe_buf.sv ----
// Purpose: Two-entry buffer for outbound read data
// Assumes: Single clock
// Notes:   Flush drops held words at frame end
`timescale 1ns/10ps
`default_nettype none

module sfcfe_buf (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       flush,
  // Filling side
  input  wire logic [7:0] inData,
  input  wire logic       inValid,
  output logic            inReady,
  // Draining side
  output logic      [7:0] outData,
  output logic            outValid,
  input  wire logic       outReady
);

  logic [7:0] mem [2];
  logic       wrPtr_reg;
  logic       rdPtr_reg;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic       push;
  logic       pop;

  assign outValid = (cnt_reg != 2'h0);
  assign outData  = mem[rdPtr_reg];
  assign push     = inValid && inReady && !flush;
  assign pop      = outValid && outReady && !flush;

  always_comb begin
    cnt_next = cnt_reg;
    if (flush) begin
      cnt_next = 2'h0;
    end else if (push && !pop) begin
      cnt_next = cnt_reg + 2'h1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_reg <= 1'b0;
      rdPtr_reg <= 1'b0;
      cnt_reg   <= 2'h0;
      inReady   <= 1'b1;
    end else begin
      wrPtr_reg <= flush ? 1'b0 : (wrPtr_reg ^ push);
      rdPtr_reg <= flush ? 1'b0 : (rdPtr_reg ^ pop);
      cnt_reg   <= cnt_next;
      inReady   <= (cnt_next != 2'h2);
    end
  end

endmodule : sfcfe_buf
`default_nettype wire

// ---- bench/sfcfe_host.sv ----
// Purpose: Host controller model driving the serial pins
// Assumes: 64 ns serial clock, either idle level
// Notes:   Released data lines show the inverted last value
`timescale 1ns/10ps
`default_nettype none

module sfcfe_host (
  // Pins toward the device
  output var logic       csN,
  output var logic       sclk,
  output var logic [3:0] ioIn,
  // Device answers
  input  wire logic [3:0] ioOut
);
  logic idlePol;

  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    ioIn = 4'hA;
    idlePol = 1'b0;
  end

  // ************************************************
  // Frame tasks
  // ************************************************
  task automatic open_frame(input logic pol);
    idlePol = pol;
    sclk = pol;
    #100;
    csN = 1'b0;
    #40;
  endtask : open_frame

  // Data set while low, taken by the device at the rise
  task automatic pulse(input logic [3:0] d);
    sclk = 1'b0;
    ioIn = d;
    #32;
    sclk = 1'b1;
    #32;
  endtask : pulse

  // Bits MSB first, or nibbles high first in quad
  task automatic send(input logic [7:0] b, input logic quad, input int n);
    for (int i = 0; i < n; i++) begin
      if (quad) pulse(i[0] ? b[3:0] : b[7:4]);
      else pulse({~ioIn[3:1], b[3'd7 - i[2:0]]});
    end
  endtask : send

  // Late sample, just before the next fall
  task automatic receive(output logic [7:0] b, input int n);
    b = 8'h00;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      #32;
      sclk = 1'b1;
      #32;
      b = {b[6:0], ioOut[1]};
    end
  endtask : receive

  task automatic close_frame();
    sclk = idlePol;
    #20;
    csN = 1'b1;
    ioIn = ~ioIn;
    #100;
  endtask : close_frame
endmodule : sfcfe_host

`default_nettype wire

// ---- bench/serial_flash_command_front_end_bench.sv ----
// Purpose: Self-checking bench of the command front end
// Assumes: Host model on the pins, bench acts as core
// Notes:   Scenarios run in sequence after reset
`timescale 1ns/10ps
`default_nettype none

module serial_flash_command_front_end_bench;
  import sfcfe_pkg::*;
  logic clk, rstn, busy, rdValid;
  logic csN, sclk, cmdValid, rdReady, active, quadMode, fastMode;
  logic [7:0] rdData, got;
  logic [3:0] ioIn, ioOut, ioOeN, ioLine;
  sfcfe_cmd_t cmd, lastCmd;
  int failures = 0, tests_run = 0, nCmd = 0, nb;

  always #4 clk = ~clk;

  // Undriven lanes read back inverted
  assign ioLine = ioOut ^ ioOeN;

  sfcfe_host sfcfe_host_inst (.csN(csN), .sclk(sclk), .ioIn(ioIn), .ioOut(ioLine));

  sfcfe_top sfcfe_top_inst (.clk(clk), .rstn(rstn), .csN(csN), .sclk(sclk), .ioIn(ioIn),
    .ioOut(ioOut), .ioOeN(ioOeN), .busy(busy), .cmdValid(cmdValid), .cmd(cmd),
    .rdData(rdData), .rdValid(rdValid), .rdReady(rdReady), .active(active),
    .quad_command_mode(quadMode), .fast_quad_read_mode(fastMode));

  // Count decoded commands mid-pulse
  always @(negedge clk) begin
    if (cmdValid === 1'b1) begin
      nCmd++;
      lastCmd = cmd;
    end
  end

  // ************************************************
  // Shared tasks
  // ************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic push(input logic [7:0] d);
    int k;
    @(negedge clk);
    rdData = d;
    rdValid = 1'b1;
    k = 0;
    while (rdReady !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    check(rdReady, 1'b1, "push taken");
    @(negedge clk);
    rdValid = 1'b0;
  endtask : push

  task automatic send_addr(input logic [23:0] a, input logic quad);
    for (int i = 2; i >= 0; i--) sfcfe_host_inst.send(a[8*i +: 8], quad, quad ? 2 : 8);
  endtask : send_addr

  // ************************************************
  // Scenarios
  // ************************************************
  task automatic t_status();
    nb = nCmd;
    sfcfe_host_inst.open_frame(1'b0);
    sfcfe_host_inst.send(8'h05, 1'b0, 8);
    #100;
    check(nCmd, nb + 1, "status cmd");
    check(lastCmd.opcode, 8'h05, "status op");
    push(8'hA5);
    push(8'h3C);
    @(negedge clk);
    check(rdReady, 1'b0, "buffer full");
    sfcfe_host_inst.receive(got, 8);
    check(got, 8'hA5, "first byte");
    check(ioOeN, 4'hD, "single drive");
    sfcfe_host_inst.receive(got, 4);
    check(got, 8'h03, "cut byte");
    sfcfe_host_inst.close_frame();
    check(ioOeN, 4'hF, "released");
  endtask : t_status

  task automatic t_read(input logic pol, input logic [7:0] op, input logic [23:0] a);
    nb = nCmd;
    sfcfe_host_inst.open_frame(pol);
    sfcfe_host_inst.send(op, 1'b0, 8);
    sfcfe_host_inst.send(a[23:16], 1'b0, 8);
    check(active, 1'b1, "active");
    sfcfe_host_inst.send(a[15:8], 1'b0, 8);
    sfcfe_host_inst.send(a[7:0], 1'b0, 8);
    if (op == 8'h0B) begin
      sfcfe_host_inst.send(8'h00, 1'b0, 7);
      #100;
      check(nCmd, nb, "dummy wait");
      sfcfe_host_inst.send(8'h00, 1'b0, 1);
    end
    #100;
    check(nCmd, nb + 1, "read cmd");
    check(lastCmd.opcode, op, "read op");
    check(lastCmd.addr, a, "addr");
    check(lastCmd.sector, a[23:12], "sector");
    check(lastCmd.blk32, a[23:15], "blk32");
    check(lastCmd.blk64, a[23:16], "blk64");
    sfcfe_host_inst.close_frame();
    check(active, 1'b0, "inactive");
  endtask : t_read

  task automatic t_unknown();
    nb = nCmd;
    sfcfe_host_inst.open_frame(1'b0);
    sfcfe_host_inst.send(8'h77, 1'b0, 8);
    sfcfe_host_inst.send(8'h05, 1'b0, 8);
    #100;
    check(active, 1'b0, "standby");
    check(ioOeN, 4'hF, "undriven");
    sfcfe_host_inst.receive(got, 8);
    check(ioOeN, 4'hF, "undriven");
    sfcfe_host_inst.close_frame();
    check(nCmd, nb, "ignored");
  endtask : t_unknown

  task automatic t_quad();
    nb = nCmd;
    sfcfe_host_inst.open_frame(1'b1);
    sfcfe_host_inst.send(8'h35, 1'b0, 7);
    sfcfe_host_inst.close_frame();
    check(quadMode, 1'b0, "cut write");
    sfcfe_host_inst.open_frame(1'b1);
    sfcfe_host_inst.send(8'h35, 1'b0, 8);
    sfcfe_host_inst.close_frame();
    check(quadMode, 1'b1, "quad on");
    sfcfe_host_inst.open_frame(1'b0);
    sfcfe_host_inst.send(8'hEB, 1'b1, 2);
    send_addr(24'h1F0F5A, 1'b1);
    sfcfe_host_inst.send(8'h00, 1'b1, 5);
    #100;
    check(nCmd, nb + 1, "six dummies");
    sfcfe_host_inst.send(8'h00, 1'b1, 1);
    #100;
    check(lastCmd.addr, 24'h1F0F5A, "quad addr");
    check(fastMode, 1'b1, "fast read");
    sfcfe_host_inst.close_frame();
    sfcfe_host_inst.open_frame(1'b0);
    sfcfe_host_inst.send(8'hF5, 1'b1, 2);
    sfcfe_host_inst.close_frame();
    check(quadMode, 1'b0, "quad off");
    check(nCmd, nb + 3, "quad count");
  endtask : t_quad

  task automatic t_busy(input logic b);
    nb = nCmd;
    @(negedge clk);
    busy = b;
    sfcfe_host_inst.open_frame(1'b0);
    sfcfe_host_inst.send(8'h20, 1'b0, 8);
    send_addr(24'h2F3000, 1'b0);
    sfcfe_host_inst.close_frame();
    check(nCmd, nb + (b ? 0 : 1), "erase");
    sfcfe_host_inst.open_frame(1'b0);
    sfcfe_host_inst.send(8'h05, 1'b0, 8);
    sfcfe_host_inst.close_frame();
    check(nCmd, nb + (b ? 1 : 2), "status while busy");
    @(negedge clk);
    busy = 1'b0;
  endtask : t_busy

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  initial begin
    #200_000;
    failures++;
    print_verdict();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    busy = 1'b0;
    rdValid = 1'b0;
    rdData = 8'h00;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    #100;
    t_status();
    t_read(1'b1, 8'h03, 24'h0AF123);
    t_read(1'b0, 8'h0B, 24'h0F0000);
    t_unknown();
    t_read(1'b0, 8'h03, 24'h001FFF);
    t_quad();
    t_busy(1'b1);
    t_busy(1'b0);
    print_verdict();
  end
endmodule : serial_flash_command_front_end_bench

`default_nettype wire
